// ### mimu_clk_loss.sv
// Loss-of-clock detector: watches a sampled clock for toggles.
// Assumes the monitored clock is sampled synchronously to mclk.
`timescale 1ns/1ps
module mimu_clk_loss #(
  parameter int LIMIT = mimu_pkg::LOSS_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic mon_clk,
  output logic      lost_q
);
  localparam int CW = $clog2(LIMIT + 1);

  logic          prev_q;
  logic          prev_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          lost_d;
  logic          toggle;

  if (LIMIT < 2) begin : g_chk
    $error("mimu_clk_loss: LIMIT must be at least 2");
  end

  // A monitored clock near a multiple of mclk can alias and look quiet
  assign toggle = mon_clk ^ prev_q;

  always_comb begin
    prev_d = mon_clk;
    cnt_d  = cnt_q;
    lost_d = lost_q;
    if (toggle) begin
      cnt_d  = '0;
      lost_d = 1'b0;
    end else if (cnt_q < CW'(LIMIT)) begin
      cnt_d  = cnt_q + CW'(1);
      lost_d = (cnt_q + CW'(1)) >= CW'(LIMIT);
    end
  end

  // Starts flagged lost, so a present clock clears it right after reset
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
      cnt_q  <= CW'(LIMIT);
      lost_q <= 1'b1;
    end else begin
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
      lost_q <= lost_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_loss_recover;
    toggle |=> !lost_q;
  endproperty
  a_loss_recover: assert property (p_loss_recover)
    else $error("clock loss did not clear after a toggle");

  property p_loss_raise;
    (!toggle && cnt_q == CW'(LIMIT - 1)) |=> lost_q;
  endproperty
  a_loss_raise: assert property (p_loss_raise)
    else $error("clock loss not flagged after quiet period");
endmodule

// ### mimu_host.sv
// Host processor model on the register port of the mask unit.
// Assumes single-cycle strobes and read data one cycle after the read edge.
`timescale 1ns/1ps
module mimu_host (
  input  wire logic        mclk,
  output logic             cpu_rd,
  output logic             cpu_wr,
  output logic [7:0]       cpu_addr,
  output logic [15:0]      cpu_wdata,
  input  wire logic [15:0] cpu_rdata
);
  initial begin
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_addr = 8'h00;
    cpu_wdata = 16'h0000;
  end
  // Whole words only; the strobe stands for exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge mclk);
    cpu_wr <= 1'b0;
  endtask
  // Data is taken just after the edge that sampled the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    @(posedge mclk);
    cpu_rd <= 1'b0;
    #1;
    d = cpu_rdata;
  endtask
endmodule

// ### mimu_master_mask.sv
// Master interrupt mask unit: summary status, mask, test register,
// clear-on-read strobes and the interrupt output.
// Assumes single-cycle host read and write strobes synchronous to mclk.
//
// What this block does
// - A 16-bit mask register at 0Ah, reset to zero, where 1 unmasks a source.
// - Mask bit 0 gates the one-second tick, bit 1 the counter overflow.
// - Bits 2, 3 and 4 gate bit-error tester, HDLC and far-end alarm changes.
// - Bits 5 and 6 gate the low-order frame/alarm and remote alarm summaries.
// - Bits 8 and 9 gate tributary loopback and high-order framer summaries.
// - Bits 10 and 11 gate loss of transmit clock and loss of receive clock.
// - Reading the HDLC status register clears all HDLC summary latches.
// - Reading the first low-order status register clears its latches.
// - Reading the second low-order status register clears its latches.
// - Reading the high-order framer status register clears its latches.
// - A 16-bit test register at 0Ch whose bits 0 to 5 enter test mode.
// - A summary bit drives the interrupt only while its mask bit is one.
// - The one-second bit latches per tick and clears when read.
// - A clock-loss flag sets after 200 ns without a toggle, clears on one.
`timescale 1ns/1ps
module mimu_master_mask #(
  parameter int LOSS_CYCLES = mimu_pkg::LOSS_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic                        cpu_rd,
  input  wire logic                        cpu_wr,
  input  wire logic [mimu_pkg::ADDR_W-1:0] cpu_addr,
  input  wire logic [mimu_pkg::DATA_W-1:0] cpu_wdata,
  output logic      [mimu_pkg::DATA_W-1:0] cpu_rdata,
  input  wire logic                        one_second_tick,
  input  wire logic                        counter_overflow,
  input  wire logic                        bert_change,
  input  wire logic                        hdlc_change,
  input  wire logic                        far_end_alarm_channel,
  input  wire logic                        low_order_frame_alarm_summary,
  input  wire logic                        low_order_remote_alarm_summary,
  input  wire logic                        tributary_loopback_detected,
  input  wire logic                        high_order_framer_summary,
  input  wire logic                        tx_clk_mon,
  input  wire logic                        rx_clk_mon,
  output logic                             transmit_clock_lost,
  output logic                             receive_clock_lost,
  output logic                             bert_latch_clr,
  output logic                             hdlc_latch_clr,
  output logic                             far_end_alarm_channel_latch_clr,
  output logic                             lo_frame_latch_clr,
  output logic                             lo_remote_latch_clr,
  output logic                             ho_framer_latch_clr,
  output logic                             test_mode,
  output logic                             irq
);
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic [15:0] test_q;
  logic [15:0] test_d;
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [15:0] set_v;
  logic [15:0] clr_v;
  logic        rd_master;

  if (LOSS_CYCLES < 2) begin : g_chk
    $error("mimu_master_mask: LOSS_CYCLES must be at least 2");
  end

  mimu_clk_loss #(.LIMIT(LOSS_CYCLES)) u_tx_loss (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .mon_clk (tx_clk_mon),
    .lost_q  (transmit_clock_lost)
  );

  mimu_clk_loss #(.LIMIT(LOSS_CYCLES)) u_rx_loss (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .mon_clk (rx_clk_mon),
    .lost_q  (receive_clock_lost)
  );

  // Clear strobes reach the sub-block latches in the read cycle itself
  assign rd_master           = cpu_rd && cpu_addr == mimu_pkg::OFF_MASTER_STATUS;
  assign bert_latch_clr      = cpu_rd && cpu_addr == mimu_pkg::OFF_BERT_STATUS;
  assign hdlc_latch_clr      = cpu_rd && cpu_addr == mimu_pkg::OFF_HDLC_STATUS;
  assign far_end_alarm_channel_latch_clr      = cpu_rd && cpu_addr == mimu_pkg::OFF_FAR_END_ALARM_CHANNEL_STATUS;
  assign lo_frame_latch_clr  =
    cpu_rd && cpu_addr == mimu_pkg::OFF_LO_FRAME_STATUS;
  assign lo_remote_latch_clr =
    cpu_rd && cpu_addr == mimu_pkg::OFF_LO_REMOTE_STATUS;
  assign ho_framer_latch_clr =
    cpu_rd && cpu_addr == mimu_pkg::OFF_HO_FRAMER_STATUS;

  always_comb begin
    set_v = mimu_pkg::ZERO16;
    clr_v = mimu_pkg::ZERO16;
    set_v[mimu_pkg::BIT_OST]       = one_second_tick;
    set_v[mimu_pkg::BIT_COUNTER_OVERFLOW]      = counter_overflow;
    set_v[mimu_pkg::BIT_BERT]      = bert_change;
    set_v[mimu_pkg::BIT_HDLC]      = hdlc_change;
    set_v[mimu_pkg::BIT_FAR_END_ALARM_CHANNEL]      = far_end_alarm_channel;
    set_v[mimu_pkg::BIT_LO_FRAME]  = low_order_frame_alarm_summary;
    set_v[mimu_pkg::BIT_LO_REMOTE] = low_order_remote_alarm_summary;
    set_v[mimu_pkg::BIT_HO_FRAMER] = high_order_framer_summary;
    clr_v[mimu_pkg::BIT_OST]       = rd_master;
    clr_v[mimu_pkg::BIT_COUNTER_OVERFLOW]      = rd_master;
    clr_v[mimu_pkg::BIT_BERT]      = bert_latch_clr;
    clr_v[mimu_pkg::BIT_HDLC]      = hdlc_latch_clr;
    clr_v[mimu_pkg::BIT_FAR_END_ALARM_CHANNEL]      = far_end_alarm_channel_latch_clr;
    clr_v[mimu_pkg::BIT_LO_FRAME]  = lo_frame_latch_clr;
    clr_v[mimu_pkg::BIT_LO_REMOTE] = lo_remote_latch_clr;
    clr_v[mimu_pkg::BIT_HO_FRAMER] = ho_framer_latch_clr;
    // Set wins over clear so an event in the read cycle is kept
    status_d = (status_q & ~clr_v) | set_v;
    // Level summaries follow their source directly
    status_d[mimu_pkg::BIT_TRIB_LB] = tributary_loopback_detected;
    status_d[mimu_pkg::BIT_TX_LOST] = transmit_clock_lost;
    status_d[mimu_pkg::BIT_RX_LOST] = receive_clock_lost;
    status_d = status_d & mimu_pkg::MASK_IMPL;
  end

  always_comb begin
    mask_d  = mask_q;
    test_d  = test_q;
    rdata_d = rdata_q;
    if (cpu_wr && cpu_addr == mimu_pkg::OFF_INT_MASK) begin
      mask_d = cpu_wdata & mimu_pkg::MASK_IMPL;
    end
    if (cpu_wr && cpu_addr == mimu_pkg::OFF_FACTORY_TEST) begin
      // Software is expected to keep these zero outside the factory
      test_d = cpu_wdata & mimu_pkg::TEST_IMPL;
    end
    if (cpu_rd) begin
      unique case (cpu_addr)
        mimu_pkg::OFF_MASTER_STATUS: rdata_d = status_q;
        mimu_pkg::OFF_INT_MASK:      rdata_d = mask_q;
        mimu_pkg::OFF_FACTORY_TEST:  rdata_d = test_q;
        default:                     rdata_d = mimu_pkg::ZERO16;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mask_q   <= mimu_pkg::MASK_RESET;
      test_q   <= mimu_pkg::TEST_RESET;
      status_q <= mimu_pkg::ZERO16;
      rdata_q  <= mimu_pkg::ZERO16;
    end else begin
      mask_q   <= mask_d;
      test_q   <= test_d;
      status_q <= status_d;
      rdata_q  <= rdata_d;
    end
  end

  assign cpu_rdata = rdata_q;
  assign test_mode = |test_q;
  // Gating per bit keeps masked sources from ever reaching the pin
  assign irq       = |(status_q & mask_q);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_mask_wr;
    cpu_wr && cpu_addr == mimu_pkg::OFF_INT_MASK;
  endsequence

  property p_mask_write;
    s_mask_wr |=> mask_q == ($past(cpu_wdata) & mimu_pkg::MASK_IMPL);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask register did not take the write");

  property p_unused_zero;
    (mask_q & ~mimu_pkg::MASK_IMPL) == mimu_pkg::ZERO16 &&
    (test_q & ~mimu_pkg::TEST_IMPL) == mimu_pkg::ZERO16;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused register bit is nonzero");

  property p_masked_quiet;
    s_mask_wr ##0 (cpu_wdata == mimu_pkg::ZERO16) |=> !irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("interrupt raised with every source masked");

  // An unmasked event must reach the pin through the latch on the next cycle
  property p_gate_open;
    ((set_v & mask_q) != mimu_pkg::ZERO16 &&
     !(cpu_wr && cpu_addr == mimu_pkg::OFF_INT_MASK)) |=> irq;
  endproperty
  a_gate_open: assert property (p_gate_open)
    else $error("unmasked summary bit did not raise the interrupt");

  sequence s_tick_then_read;
    one_second_tick ##1 (rd_master && !one_second_tick);
  endsequence

  property p_ost_cycle;
    s_tick_then_read |-> status_q[mimu_pkg::BIT_OST]
      ##1 !status_q[mimu_pkg::BIT_OST];
  endproperty
  a_ost_cycle: assert property (p_ost_cycle)
    else $error("one-second bit did not latch and clear on read");

  property p_hdlc_clear;
    (hdlc_latch_clr && !hdlc_change) |=> !status_q[mimu_pkg::BIT_HDLC];
  endproperty
  a_hdlc_clear: assert property (p_hdlc_clear)
    else $error("HDLC summary not cleared by status read");

  property p_lo_frame_clear;
    (lo_frame_latch_clr && !low_order_frame_alarm_summary)
      |=> !status_q[mimu_pkg::BIT_LO_FRAME];
  endproperty
  a_lo_frame_clear: assert property (p_lo_frame_clear)
    else $error("low-order frame summary not cleared by read");

  property p_lo_remote_clear;
    (lo_remote_latch_clr && !low_order_remote_alarm_summary)
      |=> !status_q[mimu_pkg::BIT_LO_REMOTE];
  endproperty
  a_lo_remote_clear: assert property (p_lo_remote_clear)
    else $error("low-order remote summary not cleared by read");

  property p_ho_clear;
    (ho_framer_latch_clr && !high_order_framer_summary)
      |=> !status_q[mimu_pkg::BIT_HO_FRAMER];
  endproperty
  a_ho_clear: assert property (p_ho_clear)
    else $error("high-order framer summary not cleared by read");

  property p_test_mode;
    cpu_wr && cpu_addr == mimu_pkg::OFF_FACTORY_TEST
      |=> test_mode == ($past(cpu_wdata[5:0]) != 6'h00);
  endproperty
  a_test_mode: assert property (p_test_mode)
    else $error("test mode does not follow the test bits");
endmodule

// ### mimu_pkg.sv
// Constants for the master interrupt mask unit: offsets, bit positions,
// reset values and clock-loss timing.
// Assumes a 16-bit host control port with byte offsets and a 50 MHz mclk.
package mimu_pkg;
  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 16;

  localparam logic [7:0]  OFF_MASTER_STATUS    = 8'h08;
  localparam logic [7:0]  OFF_INT_MASK         = 8'h0a;
  localparam logic [7:0]  OFF_FACTORY_TEST     = 8'h0c;
  localparam logic [7:0]  OFF_BERT_STATUS      = 8'h40;
  localparam logic [7:0]  OFF_HDLC_STATUS      = 8'h42;
  localparam logic [7:0]  OFF_FAR_END_ALARM_CHANNEL_STATUS      = 8'h44;
  localparam logic [7:0]  OFF_LO_FRAME_STATUS  = 8'h46;
  localparam logic [7:0]  OFF_LO_REMOTE_STATUS = 8'h48;
  localparam logic [7:0]  OFF_HO_FRAMER_STATUS = 8'h4a;

  localparam int          BIT_OST       = 0;
  localparam int          BIT_COUNTER_OVERFLOW      = 1;
  localparam int          BIT_BERT      = 2;
  localparam int          BIT_HDLC      = 3;
  localparam int          BIT_FAR_END_ALARM_CHANNEL      = 4;
  localparam int          BIT_LO_FRAME  = 5;
  localparam int          BIT_LO_REMOTE = 6;
  localparam int          BIT_TRIB_LB   = 8;
  localparam int          BIT_HO_FRAMER = 9;
  localparam int          BIT_TX_LOST   = 10;
  localparam int          BIT_RX_LOST   = 11;

  localparam logic [15:0] MASK_IMPL  = 16'h0f7f;
  localparam logic [15:0] TEST_IMPL  = 16'h003f;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] TEST_RESET = 16'h0000;
  localparam logic [15:0] ZERO16     = 16'h0000;

  localparam int          CLK_PERIOD_NS = 20;
  localparam int          LOSS_NS       = 200;
  localparam int          LOSS_CYC      = LOSS_NS / CLK_PERIOD_NS;
endpackage

// ### tb_master_interrupt_mask_unit.sv
// Self-checking bench for the master interrupt mask unit.
// Assumes the host model drives the register port; clocks are monitored.
`timescale 1ns/1ps
module tb_master_interrupt_mask_unit;
  // Short loss count keeps the clock-loss runs brief
  localparam int L = 3;
  logic        mclk;
  logic        rst_b = 1'b0;
  logic [15:0] ev = 16'h0000;
  logic [1:0]  run = 2'b11;
  logic        tx_mon = 1'b0;
  logic        rx_mon = 1'b0;
  logic [5:0]  clr_seen = 6'h00;
  logic        cpu_rd, cpu_wr, irq, test_mode, tx_lost, rx_lost;
  logic [5:0]  clr;
  logic [7:0]  cpu_addr;
  logic [15:0] cpu_wdata, cpu_rdata;
  logic [3:0]  mon;
  int          n_fail = 0;
  int          num_checks = 0;

  assign mon = {test_mode, rx_lost, tx_lost, irq};

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (run[0]) tx_mon <= ~tx_mon;
    if (run[1]) rx_mon <= ~rx_mon;
    if (cpu_rd) clr_seen <= clr;
  end

  mimu_host host_i (.mclk(mclk), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));

  mimu_master_mask #(.LOSS_CYCLES(L)) mimu_master_mask_i (
    .mclk(mclk), .rst_b(rst_b), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .one_second_tick(ev[0]), .counter_overflow(ev[1]),
    .bert_change(ev[2]), .hdlc_change(ev[3]),
    .far_end_alarm_channel(ev[4]),
    .low_order_frame_alarm_summary(ev[5]),
    .low_order_remote_alarm_summary(ev[6]),
    .tributary_loopback_detected(ev[8]),
    .high_order_framer_summary(ev[9]),
    .tx_clk_mon(tx_mon), .rx_clk_mon(rx_mon),
    .transmit_clock_lost(tx_lost), .receive_clock_lost(rx_lost),
    .bert_latch_clr(clr[0]), .hdlc_latch_clr(clr[1]),
    .far_end_alarm_channel_latch_clr(clr[2]), .lo_frame_latch_clr(clr[3]),
    .lo_remote_latch_clr(clr[4]), .ho_framer_latch_clr(clr[5]),
    .test_mode(test_mode), .irq(irq));

  task automatic final_report();
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait; running out of cycles shows up as a mismatch
  task automatic wait_bit(input int s, input logic v);
    #1;
    for (int i = 0; i < 8; i++) begin
      if (mon[s] === v) break;
      @(posedge mclk);
      #1;
    end
    chk(mon[s], v);
  endtask

  task automatic regs_test();
    logic [15:0] d;
    host_i.rd(8'h0a, d);
    chk(d, 16'h0000);
    host_i.rd(8'h0c, d);
    chk(d, 16'h0000);
    chk(irq, 1'b0);
    host_i.wr(8'h0a, 16'hffff);
    host_i.rd(8'h0a, d);
    chk(d, 16'h0f7f);
    host_i.wr(8'h0a, 16'h0000);
    host_i.wr(8'h0c, 16'hffff);
    host_i.rd(8'h0c, d);
    chk(d, 16'h003f);
    wait_bit(3, 1'b1);
    host_i.wr(8'h0c, 16'h0000);
    wait_bit(3, 1'b0);
    host_i.wr(8'h0e, 16'hffff);
    host_i.rd(8'h0e, d);
    chk(d, 16'h0000);
    host_i.rd(8'h0a, d);
    chk(d, 16'h0000);
  endtask

  // Pulse a source masked, unmask it, then clear it by its own read
  task automatic src_test(input int b, input logic [7:0] ca,
                          input logic [5:0] ce);
    logic [15:0] d;
    @(posedge mclk);
    ev[b] <= 1'b1;
    @(posedge mclk);
    ev[b] <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(irq, 1'b0);
    host_i.wr(8'h0a, 16'h0001 << b);
    wait_bit(0, 1'b1);
    host_i.rd(8'h08, d);
    chk(d & 16'h037f, 16'h0001 << b);
    if (b > 1) begin
      chk(irq, 1'b1);
      host_i.rd(ca, d);
      chk(clr_seen, ce);
    end
    wait_bit(0, 1'b0);
    host_i.rd(8'h08, d);
    chk(d & 16'h037f, 16'h0000);
    host_i.wr(8'h0a, 16'h0000);
  endtask

  // Tick in the read cycle is kept; a tick read next cycle is cleared
  task automatic ost_test();
    logic [15:0] d;
    host_i.wr(8'h0a, 16'h0001);
    fork
      begin
        @(posedge mclk);
        ev[0] <= 1'b1;
        @(posedge mclk);
        ev[0] <= 1'b0;
      end
      host_i.rd(8'h08, d);
    join
    chk(d & 16'h0001, 16'h0000);
    chk(irq, 1'b1);
    host_i.rd(8'h08, d);
    chk(d & 16'h0001, 16'h0001);
    chk(irq, 1'b0);
    fork
      begin
        @(posedge mclk);
        ev[0] <= 1'b1;
        @(posedge mclk);
        ev[0] <= 1'b0;
      end
      begin
        @(posedge mclk);
        host_i.rd(8'h08, d);
      end
    join
    chk(d & 16'h0001, 16'h0001);
    chk(irq, 1'b0);
    host_i.rd(8'h08, d);
    chk(d & 16'h0001, 16'h0000);
    host_i.wr(8'h0a, 16'h0000);
  endtask

  // Mid-run reset returns registers to zero and flags clocks lost
  task automatic reset_test();
    logic [15:0] d;
    host_i.wr(8'h0a, 16'h0f7f);
    host_i.wr(8'h0c, 16'h0001);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    chk(mon, 4'h6);
    host_i.rd(8'h0a, d);
    chk(d, 16'h0000);
    host_i.rd(8'h0c, d);
    chk(d, 16'h0000);
    wait_bit(1, 1'b0);
    wait_bit(2, 1'b0);
    chk(irq, 1'b0);
  endtask

  // Stop one monitored clock, expect the flag after L quiet samples
  task automatic loss_test(input int k);
    @(posedge mclk);
    run[k] <= 1'b0;
    repeat (L) @(posedge mclk);
    #1;
    chk(mon[1+k], 1'b0);
    @(posedge mclk);
    #1;
    chk(mon[1+k], 1'b1);
    wait_bit(1 + k, 1'b1);
    host_i.wr(8'h0a, 16'h0400 << k);
    wait_bit(0, 1'b1);
    @(posedge mclk);
    run[k] <= 1'b1;
    wait_bit(1 + k, 1'b0);
    wait_bit(0, 1'b0);
    host_i.wr(8'h0a, 16'h0000);
  endtask

  task automatic loopback_test();
    logic [15:0] d;
    host_i.wr(8'h0a, 16'h0100);
    @(posedge mclk);
    ev[8] <= 1'b1;
    wait_bit(0, 1'b1);
    host_i.rd(8'h08, d);
    chk(d & 16'h0100, 16'h0100);
    @(posedge mclk);
    ev[8] <= 1'b0;
    wait_bit(0, 1'b0);
    host_i.wr(8'h0a, 16'h0000);
  endtask

  initial begin
    #2000000;
    n_fail++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    regs_test();
    src_test(0, 8'h08, 6'h00);
    src_test(1, 8'h08, 6'h00);
    src_test(2, 8'h40, 6'h01);
    src_test(3, 8'h42, 6'h02);
    src_test(4, 8'h44, 6'h04);
    src_test(5, 8'h46, 6'h08);
    src_test(6, 8'h48, 6'h10);
    src_test(9, 8'h4a, 6'h20);
    ost_test();
    loopback_test();
    loss_test(0);
    loss_test(1);
    reset_test();
    final_report();
  end
endmodule
